/* File: design/spdif_pkg.sv */
// Shared constants, types and register map of the bi-phase mark framer.
// Assumes one clock at the unit-interval rate and a synchronous reset.
package spdif_pkg;

    // ======================================================
    // Framing
    localparam int UI_PER_SUB       = 64;
    localparam int SLOTS_PER_SUB    = 32;
    localparam int FRAMES_PER_BLOCK = 192;
    localparam int CS_WORDS         = 6;
    localparam int SAMPLE_W         = 24;
    localparam logic [5:0] UI_LAST   = 6'h3f;
    localparam logic [5:0] UI_DATA0  = 6'h08;
    localparam logic [7:0] FRAME_LAST = 8'hbf;

    // ======================================================
    // Preamble line patterns for a preceding state of zero
    localparam logic [7:0] PAT_CH_A  = 8'he2;
    localparam logic [7:0] PAT_CH_B  = 8'he4;
    localparam logic [7:0] PAT_BLOCK = 8'he8;

    // ======================================================
    // Channel-status bit meanings, bits 0 to 5
    localparam int CS_PROFESSIONAL = 0;
    localparam int CS_COMPRESSED   = 1;
    localparam int CS_COPY_PERMIT  = 2;
    localparam int CS_FOUR_CHAN    = 3;
    localparam int CS_PRE_EMPH     = 5;

    // ======================================================
    // Register map (byte addresses)
    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_AUX    = 8'h08;
    localparam logic [7:0] ADDR_CS_A   = 8'h40;
    localparam logic [7:0] ADDR_CS_B   = 8'h60;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [3:0]  AUX_RESET  = 4'h0;
    localparam logic [31:0] CS_RESET   = 32'h0000_0000;

    // ======================================================
    // Types
    typedef struct packed {
        logic [4:0] src_bits;
        logic       validity_b;
        logic       validity_a;
        logic       status_buffer_enable;
        logic       single_channel_double_rate;
        logic       width20;
        logic       enable;
    } ctrl_t;

    typedef struct packed {
        logic [23:0] left;
        logic [23:0] right;
        logic        left_valid;
        logic        right_valid;
        logic        left_user;
        logic        right_user;
    } sample_pair_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_LOAD = 3'b010,
        ST_RUN  = 3'b100
    } state_t;

    typedef enum logic [1:0] {
        PRE_X = 2'h0,
        PRE_Y = 2'h1,
        PRE_Z = 2'h2
    } pre_sel_t;

endpackage

/* File: design/bmc_line_encoder.sv */
// Line-state generator: preambles in slots 0 to 3, bi-phase mark after.
// Assumes ui counts 0..63 each subframe and data_bit is the current slot.
`timescale 1ns/10ps
module bmc_line_encoder (
    // Clock and reset
    input  wire logic                 core_clk,
    input  wire logic                 rst,
    // Framer side
    input  wire logic                 run,
    input  wire logic [5:0]           ui,
    input  spdif_pkg::pre_sel_t       pre_sel,
    input  wire logic                 data_bit,
    // Line
    output logic                      line_reg
);

    // ======================================================
    // Next line state
    logic       pol_reg;
    logic       pol_now;
    logic [7:0] pat;
    logic       pat_bit;
    logic       line_next;

    assign pat = (pre_sel == spdif_pkg::PRE_Y) ? spdif_pkg::PAT_CH_B :
                 (pre_sel == spdif_pkg::PRE_Z) ? spdif_pkg::PAT_BLOCK :
                 spdif_pkg::PAT_CH_A;
    // Polarity follows the last parity half-symbol
    assign pol_now = (ui == 6'h00) ? line_reg : pol_reg; // [R21]
    assign pat_bit = pat[3'h7 - ui[2:0]] ^ pol_now; // [R20]
    assign line_next = !run ? 1'b0 :
                       (ui < spdif_pkg::UI_DATA0) ? pat_bit : // [R2]
                       !ui[0] ? ~line_reg : // [R14] [R15]
                       (data_bit ? ~line_reg : line_reg); // [R16]

    always_ff @(posedge core_clk) begin
        if (rst) begin
            line_reg <= 1'b0;
            pol_reg  <= 1'b0;
        end else begin
            line_reg <= line_next;
            pol_reg  <= pol_now;
        end
    end

    // ======================================================
    // Checks
    chk_bmc_boundary: assert property (@(posedge core_clk) // [R15]
        disable iff (rst) run && ui >= spdif_pkg::UI_DATA0 && !ui[0]
        |=> line_reg != $past(line_reg))
        else $error("no transition at symbol boundary");
    chk_bmc_one: assert property (@(posedge core_clk) // [R16]
        disable iff (rst) run && ui >= spdif_pkg::UI_DATA0 && ui[0] &&
        data_bit |=> line_reg != $past(line_reg))
        else $error("one bit lacks mid-cell transition");
    chk_pre_first: assert property (@(posedge core_clk) // [R21]
        disable iff (rst) run && ui == 6'h00 |=> line_reg != $past(line_reg))
        else $error("preamble first state equals prior state");

endmodule

/* File: design/spdif_subframe_encoder.sv */
// Transmit framer: APB registers, channel-status store, subframe builder.
// Assumes a 40 MHz core_clk equal to the unit-interval rate, sync reset.
`timescale 1ns/10ps
// Contract
// [R1] A frame is two subframes of 32 slots, 64 unit intervals each.
// [R2] Slots 0 to 3 of every subframe carry the preamble.
// [R3] Full width: 24-bit sample in slots 4 to 27, LSB first.
// [R4] 20-bit mode: sample in slots 8 to 27, slots 4 to 7 auxiliary.
// [R5] Sample bits the source lacks are sent as zero in low positions.
// [R6] Slot 28 holds validity: zero means fit for analog conversion.
// [R7] Validity set by buffer enable with channel control, or sample flag.
// [R8] Slot 29 holds the user flag of the matching sample.
// [R9] Slot 30 carries one status bit; 192-bit block per channel.
// [R10] Status bit 0 goes in the frame starting with block preamble.
// [R11] Slot 31 parity makes slots 4 to 31 even in ones.
// [R12] Subframe A preamble is X, or Z once every 192 frames.
// [R13] Subframe B always starts with preamble Y.
// [R14] Slots 4 to 31 are sent in bi-phase mark code.
// [R15] Each symbol's first state differs from previous second state.
// [R16] Second state repeats the first for zero, differs for one.
// [R17] Two modes: stereo at frame rate, or one channel doubled.
// [R18] User bits of A and B form one stream in sent order.
// [R19] Status bits 0-5: pro, compressed, copy, four-chan, unused, emphasis.
// [R20] Preambles X, Y, Z as eight states, inverted after a high state.
// [R21] Preamble first state differs from parity symbol's last state.
// [R22] One-cycle request for each pair before the frame; one state per clock.
module spdif_subframe_encoder (
    // Clock and reset
    input  wire logic                    core_clk,
    input  wire logic                    rst,
    // APB slave
    input  wire logic                    psel,
    input  wire logic                    penable,
    input  wire logic                    pwrite,
    input  wire logic [7:0]              paddr,
    input  wire logic [31:0]             pwdata,
    output logic                         pready,
    output logic [31:0]                  prdata,
    output logic                         pslverr,
    // Sample source
    input  spdif_pkg::sample_pair_t      sample_in,
    output logic                         sample_req,
    // Serial line
    output logic                         line_out
);

    // ======================================================
    // Registers
    spdif_pkg::ctrl_t       ctrl_reg;
    logic [3:0]             aux_reg;
    logic [31:0]            cs_a_mem [spdif_pkg::CS_WORDS];
    logic [31:0]            cs_b_mem [spdif_pkg::CS_WORDS];
    spdif_pkg::state_t      state_reg;
    spdif_pkg::sample_pair_t pair_reg;
    logic [5:0]             ui_reg;
    logic                   sub_b_reg;
    logic [7:0]             frame_reg;
    logic [27:0]            word_reg;
    logic                   pready_reg;
    logic [31:0]            prdata_reg;
    logic                   pslverr_reg;
    logic                   sample_req_reg;

    // ======================================================
    // Helpers
    // Word index of a channel-status region, or 7 when outside it
    function automatic logic [2:0] cs_index(input logic [7:0] addr,
                                            input logic [7:0] base);
        logic [7:0] off;
        off = addr - base;
        cs_index = (addr >= base && off < 8'h18 && off[1:0] == 2'h0) ?
                   off[4:2] : 3'h7;
    endfunction

    // Keep the top n bits of a 24-bit word and zero the rest, unless n is 0 or reaches the field
    function automatic logic [23:0] keep_top(input logic [23:0] s,
                                             input logic [4:0] n,
                                             input logic [4:0] field);
        logic [4:0] lost;
        // Field is MSB-aligned, so the cut counts down from bit 23
        lost = (n == 5'h00 || n >= field) ? 5'h00 : 5'h18 - n;
        keep_top = s & (24'hffffff << lost);
    endfunction

    // Slots 4..31 of one subframe, slot 4 in bit 0, parity on top
    function automatic logic [27:0] build_word(input logic [23:0] s,
                                               input logic [3:0] aux,
                                               input logic v,
                                               input logic u,
                                               input logic c,
                                               input spdif_pkg::ctrl_t k);
        logic [23:0] audio;
        logic [23:0] kept;
        logic [26:0] body;
        kept = keep_top(s, k.src_bits, k.width20 ? 5'h14 : 5'h18); // [R5]
        audio = k.width20 ? {kept[23:4], aux} : kept; // [R3] [R4]
        body = {c, u, v, audio}; // [R6] [R8] [R9]
        build_word = {^body, body}; // [R11]
    endfunction

    // ======================================================
    // APB decode
    logic        apb_access;
    logic        apb_done;
    logic [2:0]  cs_a_idx;
    logic [2:0]  cs_b_idx;
    logic        hit_ctrl;
    logic        hit_status;
    logic        hit_aux;
    logic        hit_any;
    logic [31:0] status_word;
    logic [31:0] read_word;

    assign apb_access = psel && penable && !pready_reg;
    assign apb_done   = psel && penable && pready_reg;
    assign cs_a_idx   = cs_index(paddr, spdif_pkg::ADDR_CS_A);
    assign cs_b_idx   = cs_index(paddr, spdif_pkg::ADDR_CS_B);
    assign hit_ctrl   = paddr == spdif_pkg::ADDR_CTRL;
    assign hit_status = paddr == spdif_pkg::ADDR_STATUS;
    assign hit_aux    = paddr == spdif_pkg::ADDR_AUX;
    assign hit_any    = hit_ctrl || hit_status || hit_aux ||
                        cs_a_idx != 3'h7 || cs_b_idx != 3'h7;
    assign status_word = {14'h0,
                          cs_a_mem[0][spdif_pkg::CS_PROFESSIONAL], // [R19]
                          sub_b_reg, frame_reg, 7'h0,
                          state_reg == spdif_pkg::ST_RUN};
    assign read_word = hit_ctrl ? {19'h0, ctrl_reg.src_bits, 2'h0,
                                   ctrl_reg[5:0]} :
                       hit_status ? status_word :
                       hit_aux ? {28'h0, aux_reg} :
                       cs_a_idx != 3'h7 ? cs_a_mem[cs_a_idx] :
                       cs_b_idx != 3'h7 ? cs_b_mem[cs_b_idx] : 32'h0;

    // Answer one cycle into the access phase; write lands at the last edge
    always_ff @(posedge core_clk) begin
        if (rst) begin
            pready_reg  <= 1'b0;
            prdata_reg  <= 32'h0;
            pslverr_reg <= 1'b0;
        end else begin
            pready_reg  <= apb_access;
            prdata_reg  <= apb_access && !pwrite ? read_word : 32'h0;
            pslverr_reg <= apb_access && !hit_any;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            ctrl_reg <= spdif_pkg::ctrl_t'(spdif_pkg::CTRL_RESET[10:0]);
            aux_reg  <= spdif_pkg::AUX_RESET;
        end else if (apb_done && pwrite && hit_ctrl) begin
            ctrl_reg <= spdif_pkg::ctrl_t'({pwdata[12:8], pwdata[5:0]});
        end else if (apb_done && pwrite && hit_aux) begin
            aux_reg <= pwdata[3:0];
        end
    end

    // Status store, 192 bits per channel in six words
    generate
        for (genvar i = 0; i < spdif_pkg::CS_WORDS; i++) begin : g_cs
            always_ff @(posedge core_clk) begin
                if (rst) begin
                    cs_a_mem[i] <= spdif_pkg::CS_RESET;
                    cs_b_mem[i] <= spdif_pkg::CS_RESET;
                end else if (apb_done && pwrite) begin
                    if (cs_a_idx == 3'(i))
                        cs_a_mem[i] <= pwdata; // [R9]
                    if (cs_b_idx == 3'(i))
                        cs_b_mem[i] <= pwdata; // [R9]
                end
            end
        end
    endgenerate

    // ======================================================
    // Framing counters and sequencing
    logic        at_last;
    logic        frame_wrap;
    logic [7:0]  frame_inc;
    logic [7:0]  frame_new;
    logic        keep_going;
    logic        a_cs;
    logic        b_cs;
    logic        a_val;
    logic        b_val;
    logic [27:0] word_a_new;
    logic [27:0] word_b;
    logic        data_bit;
    logic        run;
    spdif_pkg::pre_sel_t pre_sel;

    assign run        = state_reg == spdif_pkg::ST_RUN;
    assign at_last    = ui_reg == spdif_pkg::UI_LAST;
    assign frame_wrap = frame_reg == spdif_pkg::FRAME_LAST;
    assign frame_inc  = frame_wrap ? 8'h00 : frame_reg + 8'h01; // [R12]
    assign frame_new  = (state_reg == spdif_pkg::ST_LOAD) ? 8'h00 : frame_inc;
    assign keep_going = ctrl_reg.enable;

    // Status bit index is the frame number; bit 0 rides the Z frame
    assign a_cs = cs_a_mem[frame_new[7:5]][frame_new[4:0]]; // [R10]
    // Doubled rate keeps channel A status and validity in both halves
    assign b_cs = ctrl_reg.single_channel_double_rate ?
                  cs_a_mem[frame_reg[7:5]][frame_reg[4:0]] :
                  cs_b_mem[frame_reg[7:5]][frame_reg[4:0]]; // [R17]
    assign a_val = (ctrl_reg.status_buffer_enable && ctrl_reg.validity_a) ||
                   sample_in.left_valid; // [R7]
    assign b_val = (ctrl_reg.status_buffer_enable &&
                    (ctrl_reg.single_channel_double_rate ?
                     ctrl_reg.validity_a : ctrl_reg.validity_b)) ||
                   pair_reg.right_valid; // [R7] [R17]
    // User flags simply follow the subframe order
    assign word_a_new = build_word(sample_in.left, aux_reg, a_val,
                                   sample_in.left_user, a_cs,
                                   ctrl_reg); // [R18]
    assign word_b = build_word(pair_reg.right, aux_reg, b_val,
                               pair_reg.right_user, b_cs,
                               ctrl_reg); // [R18]
    assign pre_sel = sub_b_reg ? spdif_pkg::PRE_Y : // [R13]
                     (frame_reg == 8'h00) ? spdif_pkg::PRE_Z :
                     spdif_pkg::PRE_X; // [R12]
    assign data_bit = word_reg[0];

    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_reg      <= spdif_pkg::ST_IDLE;
            ui_reg         <= 6'h00;
            sub_b_reg      <= 1'b0;
            frame_reg      <= 8'h00;
            word_reg       <= 28'h0;
            pair_reg       <= '0;
            sample_req_reg <= 1'b0;
        end else begin
            sample_req_reg <= 1'b0;
            case (state_reg)
                spdif_pkg::ST_IDLE: begin
                    ui_reg    <= 6'h00;
                    sub_b_reg <= 1'b0;
                    if (ctrl_reg.enable) begin
                        sample_req_reg <= 1'b1; // [R22]
                        state_reg      <= spdif_pkg::ST_LOAD;
                    end
                end
                spdif_pkg::ST_LOAD: begin
                    // Spare clock so a registered source can answer
                    if (ui_reg == 6'h00) begin
                        ui_reg <= 6'h01;
                    end else begin
                        ui_reg    <= 6'h00;
                        pair_reg  <= sample_in;
                        word_reg  <= word_a_new;
                        frame_reg <= 8'h00;
                        state_reg <= spdif_pkg::ST_RUN;
                    end
                end
                spdif_pkg::ST_RUN: begin
                    ui_reg <= ui_reg + 6'h01; // [R1] [R22]
                    // Shift after the second half of each data slot
                    if (ui_reg[0] && ui_reg >= spdif_pkg::UI_DATA0)
                        word_reg <= {1'b0, word_reg[27:1]}; // [R3]
                    if (sub_b_reg && ui_reg == 6'h00 && keep_going)
                        sample_req_reg <= 1'b1; // [R22]
                    if (at_last) begin
                        sub_b_reg <= !sub_b_reg; // [R1]
                        if (!sub_b_reg) begin
                            word_reg <= word_b;
                        end else if (keep_going) begin
                            frame_reg <= frame_inc;
                            pair_reg  <= sample_in;
                            word_reg  <= word_a_new;
                        end else begin
                            // Stop only on a frame boundary
                            state_reg <= spdif_pkg::ST_IDLE;
                            frame_reg <= 8'h00;
                        end
                    end
                end
                default: state_reg <= spdif_pkg::ST_IDLE;
            endcase
        end
    end

    // ======================================================
    // Line encoder
    bmc_line_encoder u_enc (
        .core_clk (core_clk),
        .rst      (rst),
        .run      (run),
        .ui       (ui_reg),
        .pre_sel  (pre_sel),
        .data_bit (data_bit),
        .line_reg (line_out)
    );

    assign pready     = pready_reg;
    assign prdata     = prdata_reg;
    assign pslverr    = pslverr_reg;
    assign sample_req = sample_req_reg;

    // ======================================================
    // Checks
    chk_req_single_pulse: assert property (@(posedge core_clk) // [R22]
        disable iff (rst) sample_req |=> !sample_req)
        else $error("sample request longer than one cycle");
    chk_frame_wrap_192: assert property (@(posedge core_clk) // [R12]
        disable iff (rst) run && at_last && sub_b_reg && frame_wrap &&
        keep_going |=> frame_reg == 8'h00)
        else $error("block did not wrap after 192 frames");
    chk_frame_in_range: assert property (@(posedge core_clk) // [R9]
        disable iff (rst) frame_reg <= spdif_pkg::FRAME_LAST)
        else $error("frame index out of range");
    chk_parity_even: assert property (@(posedge core_clk) // [R11]
        disable iff (rst) run && ui_reg == 6'h07 |-> ^word_reg == 1'b0)
        else $error("subframe parity not even");
    chk_sub_toggle: assert property (@(posedge core_clk) // [R1]
        disable iff (rst) run && at_last && !sub_b_reg
        |=> sub_b_reg && ui_reg == 6'h00)
        else $error("subframe length not 64 states");
    chk_pre_b_is_y: assert property (@(posedge core_clk) // [R13]
        disable iff (rst) run && sub_b_reg |-> pre_sel == spdif_pkg::PRE_Y)
        else $error("second subframe lacks Y preamble");
    chk_req_before_frame: assert property (@(posedge core_clk) // [R22]
        disable iff (rst) run && sub_b_reg && ui_reg == 6'h00 && keep_going
        |=> sample_req)
        else $error("no sample request ahead of frame");
    chk_valid_forced: assert property (@(posedge core_clk) // [R7]
        disable iff (rst) run && at_last && !sub_b_reg &&
        ctrl_reg.status_buffer_enable && ctrl_reg.validity_b &&
        !ctrl_reg.single_channel_double_rate |=> word_reg[24])
        else $error("channel B validity not forced");
    chk_user_bit_b: assert property (@(posedge core_clk) // [R8]
        disable iff (rst) run && at_last && !sub_b_reg
        |=> word_reg[25] == $past(pair_reg.right_user))
        else $error("user bit mismatch");

    cov_block_start: cover property (@(posedge core_clk)
        run && ui_reg == 6'h00 && pre_sel == spdif_pkg::PRE_Z);
    cov_double_rate: cover property (@(posedge core_clk)
        run && ctrl_reg.single_channel_double_rate && at_last);
    cov_width20: cover property (@(posedge core_clk)
        run && ctrl_reg.width20 && at_last);
    cov_stop: cover property (@(posedge core_clk)
        run && at_last && sub_b_reg && !keep_going);

endmodule

/* File: dv/spdif_rx_model.sv */
// Receiver model: finds preambles on the line and decodes 28 symbols.
// Assumes one line state per core_clk edge, line low while stopped.
`timescale 1ns/10ps
module spdif_rx_model (
    // Clock and line
    input  wire logic        core_clk,
    input  wire logic        line_in,
    // Decoded subframe, bit i is slot 4+i
    output logic             done,
    output logic [1:0]       kind,
    output logic [27:0]      bits,
    output logic             bad
);
    // ======================================================
    // Decoder
    logic [8:0]  h = 9'h000;
    logic [55:0] d;
    logic [7:0]  p;
    logic [27:0] b_val;
    logic        b_err;
    logic        last;
    int          n = 0;

    always @(posedge core_clk) begin
        done <= 1'b0;
        h = {h[7:0], line_in};
        p = h[7] ? h[7:0] : ~h[7:0];
        if (n > 0) begin
            d = {d[54:0], line_in};
            n = n - 1;
            if (n == 0) begin
                b_err = 1'b0;
                for (int i = 0; i < 28; i++) begin
                    b_err = b_err | (d[55-2*i] == last);
                    b_val[i] = d[55-2*i] ^ d[54-2*i];
                    last = d[54-2*i];
                end
                bits <= b_val;
                bad <= b_err;
                done <= 1'b1;
            end
        // Only a preamble holds three equal states, so no false lock
        end else if (h[8] != h[7] && (p == 8'he2 || p == 8'he4 ||
                     p == 8'he8)) begin
            kind <= {p[3], p[2]};
            last = h[0];
            n = 56;
        end
    end
endmodule

/* File: dv/spdif_subframe_encoder_tb.sv */
// Bench: APB set-up, random sample pairs, decoded line versus a model.
// Assumes spdif_rx_model beside it and the encoder package.
`timescale 1ns/10ps
module spdif_subframe_encoder_tb;
    // ======================================================
    // Signals
    logic                    core_clk = 1'b0;
    logic                    rst = 1'b1;
    logic                    psel = 1'b0;
    logic                    penable = 1'b0;
    logic                    pwrite = 1'b0;
    logic [7:0]              paddr = 8'h00;
    logic [31:0]             pwdata = 32'h0;
    logic [31:0]             lfsr = 32'h0000c230;
    logic [31:0]             prdata, rd;
    logic                    pready, pslverr, sample_req, line_out;
    logic                    err, done, bad;
    logic [27:0]             bits;
    logic [1:0]              kind;
    logic [31:0]             cs_a [6];
    logic [31:0]             cs_b [6];
    spdif_pkg::sample_pair_t sample_in = '0;
    spdif_pkg::sample_pair_t p;
    spdif_pkg::sample_pair_t q [$];
    int n_mismatch = 0, checked = 0, f = 0, s = 0, cyc = 0, t_req = 0;
    int f_sw = 1000;

    initial forever #12.5 core_clk = ~core_clk;
    always @(posedge core_clk) cyc <= cyc + 1;

    spdif_subframe_encoder DUT (.core_clk(core_clk), .rst(rst),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .sample_in(sample_in),
        .sample_req(sample_req), .line_out(line_out));
    spdif_rx_model rx (.core_clk(core_clk), .line_in(line_out),
        .done(done), .kind(kind), .bits(bits), .bad(bad));

    // ======================================================
    // Helpers
    function automatic logic [31:0] nxt(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction

    // Parity is worked out here so a wrong slot 31 shows up
    function automatic logic [27:0] sub(input logic [23:0] a,
                                        input logic v, u, c);
        logic [27:0] w;
        w = {1'b0, c, u, v, a};
        w[27] = ^w[26:0];
        return w;
    endfunction

    // Sixteen source bits in the 20-bit field: next four zero, aux below
    function automatic logic [23:0] aud(input logic [23:0] x, input logic m);
        return m ? {x[23:8], 4'h0, 4'h5} : x;
    endfunction

    function automatic logic csb(input int fr, input logic use_a);
        return use_a ? cs_a[fr % 192 / 32][fr % 32] :
                       cs_b[fr % 192 / 32][fr % 32];
    endfunction

    task automatic check(input string nm, input logic [31:0] seen, exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] wd, output logic [31:0] r,
                       output logic e);
        @(posedge core_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic results();
        if (n_mismatch == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // ======================================================
    // Sample source and line comparison
    always @(posedge core_clk) begin
        if (sample_req === 1'b1) begin
            lfsr = nxt(nxt(lfsr));
            p = {lfsr[23:0], lfsr[31:8], lfsr[3:0]};
            sample_in <= p;
            q.push_back(p);
            // The first request follows enable, not a frame
            if (t_req != 0 && f > 0)
                check("req spacing", cyc - t_req, 128);
            t_req = cyc;
        end
    end

    always @(posedge core_clk) begin
        if (done === 1'b1) begin
            if (s == 0) begin
                check("kind a", kind, (f % 192 == 0) ? 2 : 0);
                check("sub a", bits, sub(aud(q[0].left, f > f_sw),
                      f > f_sw || q[0].left_valid, q[0].left_user,
                      csb(f, 1'b1)));
            end else begin
                check("kind b", kind, 1);
                check("sub b", bits, sub(aud(q[0].right, f >= f_sw), 1'b1,
                      q[0].right_user, csb(f, f >= f_sw)));
                void'(q.pop_front());
                f++;
            end
            check("coding", bad, 0);
            s = 1 - s;
        end
    end

    // ======================================================
    // Main sequence and watchdog
    initial begin
        repeat (20) @(posedge core_clk);
        rst <= 1'b0;
        apb(1'b0, 8'h00, 32'h0, rd, err);
        check("ctrl reset", rd, 32'h0);
        apb(1'b0, 8'h0c, 32'h0, rd, err);
        check("unmapped err", err, 1);
        check("unmapped data", rd, 0);
        for (int i = 0; i < 12; i++) begin
            lfsr = nxt(lfsr);
            if (i < 6) cs_a[i] = lfsr;
            else cs_b[i-6] = lfsr;
            apb(1'b1, 8'h40 + 8'(4 * i) + (i < 6 ? 8'h00 : 8'h08),
                lfsr, rd, err);
        end
        apb(1'b0, 8'h40, 32'h0, rd, err);
        check("status word", rd, cs_a[0]);
        // Enable, status buffer enable, channel B validity forced
        apb(1'b1, 8'h08, 32'h5, rd, err);
        apb(1'b1, 8'h00, 32'h0000_0029, rd, err);
        apb(1'b0, 8'h00, 32'h0, rd, err);
        check("ctrl", rd, 32'h0000_0029);
        while (f < 150) @(posedge core_clk);
        // 20-bit field, 16 source bits, doubled rate, channel A validity
        f_sw = f;
        apb(1'b1, 8'h00, 32'h0000_101f, rd, err);
        while (f < 194) @(posedge core_clk);
        results();
    end

    initial begin
        repeat (40000) @(posedge core_clk);
        n_mismatch++;
        results();
    end
endmodule
